// ### logic/sfce_pkg.sv
/*
  Constants and carrier types of the serial flash command engine: opcodes,
  frame bit counts, address field positions, status byte layout, timing.
  Assumes a core clock of 200 MHz and a host driving the serial link in
  SPI mode 0 or 3, most significant bit first.
*/
// How it works
// RL1 - Page read: opcode, address, 32 dummies
// RL2 - Address: 4 reserved, 11 page, 9 byte
// RL3 - One read bit per clock after dummies
// RL4 - Page read wraps within same page
// RL5 - Page read leaves both buffers untouched
// RL6 - Host holds select low whole read
// RL7 - Select rise ends read, output floats
// RL8 - Buffer read: opcode, 15 dummies, offset, 8 dummies
// RL9 - Buffer read wraps to byte zero
// RL10 - Status opcode, eight bits MSB first
// RL11 - Status byte repeats with fresh values
// RL12 - Bit 7 one when ready, zero busy
// RL13 - Stopped clock shows bit 7 rising live
// RL14 - Bit 6 holds latest compare result; the code always drives it from CMP_RESET (0)
// RL15 - Bits 5-2 density code, low bits reserved
// RL16 - Buffer write: opcode, dummies, offset, data
// RL17 - Buffer write wraps to byte zero
// RL18 - Program with erase on select rise
// RL19 - Program without erase on select rise
// RL20 - Host programs only previously erased pages
// RL21 - Page erase to ones on select rise
// RL22 - Block erase of eight pages to ones
// RL23 - All fields most significant bit first
// RL24 - Sample on rising, launch on falling edge
// RL25 - Partial command starts no operation
package sfce_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_PAGE_RD    = 8'h52;
  localparam logic [7:0] OPC_PAGE_RD_A  = 8'hd2;
  localparam logic [7:0] OPC_BUF1_RD    = 8'h54;
  localparam logic [7:0] OPC_BUF1_RD_A  = 8'hd4;
  localparam logic [7:0] OPC_BUF2_RD    = 8'h56;
  localparam logic [7:0] OPC_BUF2_RD_A  = 8'hd6;
  localparam logic [7:0] OPC_STAT       = 8'h57;
  localparam logic [7:0] OPC_STAT_A     = 8'hd7;
  localparam logic [7:0] OPC_BUF1_WR    = 8'h84;
  localparam logic [7:0] OPC_BUF2_WR    = 8'h87;
  localparam logic [7:0] OPC_PGM_ERS1   = 8'h83;
  localparam logic [7:0] OPC_PGM_ERS2   = 8'h86;
  localparam logic [7:0] OPC_PGM1       = 8'h88;
  localparam logic [7:0] OPC_PGM2       = 8'h89;
  localparam logic [7:0] OPC_PAGE_ERS   = 8'h81;
  localparam logic [7:0] OPC_BLK_ERS    = 8'h50;

  // ---------------------------------------------------------------
  // Frame bit counts and field positions
  // ---------------------------------------------------------------
  localparam logic [6:0] OPC_LAST       = 7'h07;
  localparam logic [6:0] STAT_START     = 7'h08;
  localparam logic [6:0] ADDR_LAST      = 7'h1f;
  localparam logic [6:0] HDR_BITS       = 7'h20;
  localparam logic [6:0] BUF_WR_START   = 7'h20;
  localparam logic [6:0] BUF_RD_START   = 7'h28;
  localparam logic [6:0] PAGE_RD_START  = 7'h40;
  localparam int         PAGE_LSB       = 9;
  localparam int         PAGE_MSB       = 19;
  localparam int         BYTE_MSB       = 8;
  localparam int         BLK_LSB        = 3;
  localparam logic [8:0] PAGE_BYTES     = 9'h108;
  localparam logic [8:0] PAGE_LAST      = 9'h107;
  localparam logic [2:0] BLK_LAST       = 3'h7;
  localparam logic [7:0] ERASED         = 8'hff;
  localparam logic       CMP_RESET      = 1'b0;
  localparam logic [1:0] STAT_RSVD      = 2'h0;
  localparam int         CLK_MHZ        = 200;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_NONE    = 3'b000,
    M_PAGE_RD = 3'b001,
    M_BUF_RD  = 3'b011,
    M_STAT    = 3'b010,
    M_BUF_WR  = 3'b110,
    M_ARM     = 3'b111
  } sfce_mode_t;

  typedef enum logic [1:0] {
    OP_PGM_ERS = 2'b00,
    OP_PGM     = 2'b01,
    OP_PG_ERS  = 2'b11,
    OP_BLK_ERS = 2'b10
  } sfce_op_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_WALK = 2'b01,
    SQ_HOLD = 2'b11
  } sfce_seq_t;

  typedef struct packed {
    logic        we;
    logic        and_mode;
    logic [10:0] page;
    logic [8:0]  byte_idx;
    logic [7:0]  wdata;
  } sfce_arr_req_t;

endpackage

// ### logic/sfce_engine.sv
/*
  Serial flash command engine: serial link front end on the host's serial
  clock, two page buffers, and a self-timed program/erase sequencer on clk.
  Assumes an external page array with combinational read of arr_rdata at
  the address in arr_req, and byte writes when arr_req.we is high.
*/
`timescale 1ns/10ps
module sfce_engine #(
  parameter int unsigned ERASE_PROGRAM_TIME_MAX_US = 20000,
  parameter int unsigned PROGRAM_TIME_MAX_US       = 14000,
  parameter int unsigned PAGE_ERASE_TIME_MAX_US    = 8000,
  parameter int unsigned BLOCK_ERASE_TIME_MAX_US   = 12000,
  parameter logic [3:0]  DENSITY_CODE              = 4'h5 // Arbitrary value
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    sck,
  input  wire logic                    cs_b,
  input  wire logic                    si,
  output wire logic                    so,
  output wire logic                    so_oe_b,
  output wire logic                    rdy,
  output sfce_pkg::sfce_arr_req_t      arr_req,
  input  wire logic [7:0]              arr_rdata
);

  localparam logic [31:0] EP_CYC = 32'(ERASE_PROGRAM_TIME_MAX_US * sfce_pkg::CLK_MHZ);
  localparam logic [31:0] P_CYC  = 32'(PROGRAM_TIME_MAX_US * sfce_pkg::CLK_MHZ);
  localparam logic [31:0] PE_CYC = 32'(PAGE_ERASE_TIME_MAX_US * sfce_pkg::CLK_MHZ);
  localparam logic [31:0] BE_CYC = 32'(BLOCK_ERASE_TIME_MAX_US * sfce_pkg::CLK_MHZ);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [6:0]               cnt_q;
  logic [31:0]              hdr_q;
  logic [31:0]              hdr_d;
  logic [7:0]               opc_d;
  sfce_pkg::sfce_mode_t     mode_q;
  sfce_pkg::sfce_mode_t     dec_mode;
  sfce_pkg::sfce_op_t       op_q;
  sfce_pkg::sfce_op_t       dec_op;
  logic                     bsel_q;
  logic                     dec_bsel;
  logic [6:0]               data_start;
  logic [7:0]               buf_mem_q [2][264];
  logic [7:0]               wsr_q;
  logic [2:0]               wbit_q;
  logic [8:0]               wptr_q;
  logic                     in_wdata;
  logic                     buf_we;
  logic                     arm_tgl_q;
  sfce_pkg::sfce_op_t       arm_op_q;
  logic                     arm_bsel_q;
  logic [10:0]              arm_page_q;
  logic                     rd_mode;
  logic                     in_rdata;
  logic                     so_q;
  logic                     drive_q;
  logic [2:0]               obi_q;
  logic [8:0]               rd_ptr_q;
  logic                     fetch_tgl_q;
  logic [7:0]               cur_byte;
  logic [7:0]               stat_byte;
  logic [7:0]               fetch_q;
  logic                     fetch_pend_q;
  logic                     link_rst_q;
  logic                     cs_s1;
  logic                     cs_s2;
  logic                     cs_s3;
  logic                     arm_s1;
  logic                     arm_s2;
  logic                     arm_seen_q;
  logic                     fet_s1;
  logic                     fet_s2;
  logic                     fet_s3;
  logic                     cs_rise;
  logic                     arm_new;
  logic                     fet_edge;
  logic                     ready;
  sfce_pkg::sfce_seq_t      seq_q;
  sfce_pkg::sfce_op_t       run_op_q;
  logic                     run_bsel_q;
  logic [10:0]              page_q;
  logic [8:0]               byte_q;
  logic [31:0]              tmr_q;
  sfce_pkg::sfce_arr_req_t  arr_req_q;

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  assign hdr_d = {hdr_q[30:0], si};
  assign opc_d = hdr_d[7:0];

  always_comb begin
    dec_mode = sfce_pkg::M_NONE;
    dec_op   = sfce_pkg::OP_PGM_ERS;
    dec_bsel = 1'b0;
    case (opc_d)
      sfce_pkg::OPC_PAGE_RD, sfce_pkg::OPC_PAGE_RD_A: dec_mode = sfce_pkg::M_PAGE_RD; // RL1
      sfce_pkg::OPC_BUF1_RD, sfce_pkg::OPC_BUF1_RD_A: dec_mode = sfce_pkg::M_BUF_RD; // RL8
      sfce_pkg::OPC_BUF2_RD, sfce_pkg::OPC_BUF2_RD_A: begin
        dec_mode = sfce_pkg::M_BUF_RD;
        dec_bsel = 1'b1;
      end
      sfce_pkg::OPC_STAT, sfce_pkg::OPC_STAT_A: dec_mode = sfce_pkg::M_STAT; // RL10
      sfce_pkg::OPC_BUF1_WR: dec_mode = sfce_pkg::M_BUF_WR; // RL16
      sfce_pkg::OPC_BUF2_WR: begin
        dec_mode = sfce_pkg::M_BUF_WR;
        dec_bsel = 1'b1;
      end
      sfce_pkg::OPC_PGM_ERS1, sfce_pkg::OPC_PGM_ERS2: begin // RL18
        dec_mode = sfce_pkg::M_ARM;
        dec_bsel = (opc_d == sfce_pkg::OPC_PGM_ERS2);
      end
      sfce_pkg::OPC_PGM1, sfce_pkg::OPC_PGM2: begin // RL19
        dec_mode = sfce_pkg::M_ARM;
        dec_op   = sfce_pkg::OP_PGM;
        dec_bsel = (opc_d == sfce_pkg::OPC_PGM2);
      end
      sfce_pkg::OPC_PAGE_ERS: begin // RL21
        dec_mode = sfce_pkg::M_ARM;
        dec_op   = sfce_pkg::OP_PG_ERS;
      end
      sfce_pkg::OPC_BLK_ERS: begin // RL22
        dec_mode = sfce_pkg::M_ARM;
        dec_op   = sfce_pkg::OP_BLK_ERS;
      end
      default: dec_mode = sfce_pkg::M_NONE;
    endcase
  end

  always_comb begin
    case (mode_q)
      sfce_pkg::M_PAGE_RD: data_start = sfce_pkg::PAGE_RD_START; // RL1
      sfce_pkg::M_BUF_RD:  data_start = sfce_pkg::BUF_RD_START; // RL8
      sfce_pkg::M_STAT:    data_start = sfce_pkg::STAT_START; // RL10
      default:             data_start = sfce_pkg::BUF_WR_START;
    endcase
  end

  // ---------------------------------------------------------------
  // Link input side, rising serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      cnt_q <= '0;
    end else if (cnt_q != sfce_pkg::PAGE_RD_START) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  always_ff @(posedge sck) begin
    if (cnt_q < sfce_pkg::HDR_BITS) begin
      hdr_q <= hdr_d; // RL23 RL24
    end
  end

  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      mode_q <= sfce_pkg::M_NONE;
      op_q   <= sfce_pkg::OP_PGM_ERS;
      bsel_q <= 1'b0;
    end else if (cnt_q == sfce_pkg::OPC_LAST) begin
      mode_q <= dec_mode;
      op_q   <= dec_op;
      bsel_q <= dec_bsel;
    end
  end

  // ---------------------------------------------------------------
  // Buffer write
  // ---------------------------------------------------------------
  assign in_wdata = (mode_q == sfce_pkg::M_BUF_WR) && (cnt_q >= sfce_pkg::BUF_WR_START);
  assign buf_we   = in_wdata && (wbit_q == 3'h7);

  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      wbit_q <= '0;
    end else if (in_wdata) begin
      wbit_q <= wbit_q + 3'h1;
    end
  end

  always_ff @(posedge sck) begin
    if (in_wdata) begin
      wsr_q <= {wsr_q[6:0], si};
    end
    if (cnt_q == sfce_pkg::ADDR_LAST) begin
      wptr_q <= hdr_d[sfce_pkg::BYTE_MSB:0]; // RL16
    end else if (buf_we) begin
      wptr_q <= (wptr_q >= sfce_pkg::PAGE_LAST) ? 9'h000 : wptr_q + 9'h001; // RL17
    end
    if (buf_we && (wptr_q < sfce_pkg::PAGE_BYTES)) begin
      buf_mem_q[bsel_q][wptr_q] <= {wsr_q[6:0], si}; // RL16
    end
  end

  // ---------------------------------------------------------------
  // Command arming, handed to the sequencer by toggle
  // ---------------------------------------------------------------
  always_ff @(posedge sck or posedge link_rst_q) begin
    if (link_rst_q) begin
      arm_tgl_q  <= 1'b0;
      arm_op_q   <= sfce_pkg::OP_PGM_ERS;
      arm_bsel_q <= 1'b0;
      arm_page_q <= '0;
    end else if ((cnt_q == sfce_pkg::ADDR_LAST) && (mode_q == sfce_pkg::M_ARM)) begin
      arm_tgl_q  <= ~arm_tgl_q; // RL25
      arm_op_q   <= op_q;
      arm_bsel_q <= bsel_q;
      arm_page_q <= hdr_d[sfce_pkg::PAGE_MSB:sfce_pkg::PAGE_LSB]; // RL2
    end
  end

  // ---------------------------------------------------------------
  // Link output side, falling serial clock
  // ---------------------------------------------------------------
  assign rd_mode   = (mode_q == sfce_pkg::M_PAGE_RD) || (mode_q == sfce_pkg::M_BUF_RD) ||
                     (mode_q == sfce_pkg::M_STAT);
  assign in_rdata  = rd_mode && (cnt_q >= data_start);
  assign stat_byte = {1'b0, sfce_pkg::CMP_RESET, DENSITY_CODE, sfce_pkg::STAT_RSVD}; // RL14 RL15

  always_comb begin
    case (mode_q)
      sfce_pkg::M_STAT:   cur_byte = stat_byte;
      sfce_pkg::M_BUF_RD: cur_byte = (rd_ptr_q < sfce_pkg::PAGE_BYTES) ?
                                     buf_mem_q[bsel_q][rd_ptr_q] : sfce_pkg::ERASED;
      default:            cur_byte = fetch_q;
    endcase
  end

  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin
      so_q    <= 1'b0; // RL7
      drive_q <= 1'b0;
      obi_q   <= '0;
    end else if (in_rdata) begin
      so_q    <= cur_byte[3'h7 - obi_q]; // RL3 RL24
      drive_q <= 1'b1;
      obi_q   <= obi_q + 3'h1; // RL11
    end
  end

  always_ff @(negedge sck or posedge link_rst_q) begin
    if (link_rst_q) begin
      rd_ptr_q    <= '0;
      fetch_tgl_q <= 1'b0;
    end else if ((cnt_q == sfce_pkg::HDR_BITS) && rd_mode && (mode_q != sfce_pkg::M_STAT)) begin
      rd_ptr_q    <= hdr_q[sfce_pkg::BYTE_MSB:0];
      fetch_tgl_q <= ~fetch_tgl_q;
    end else if (in_rdata && (obi_q == 3'h7) && (mode_q != sfce_pkg::M_STAT)) begin
      rd_ptr_q    <= (rd_ptr_q >= sfce_pkg::PAGE_LAST) ? 9'h000 : rd_ptr_q + 9'h001; // RL4 RL9
      fetch_tgl_q <= ~fetch_tgl_q;
    end
  end

  assign so      = ((mode_q == sfce_pkg::M_STAT) && drive_q && (obi_q == 3'h1)) ?
                   ready : so_q; // RL12 RL13
  assign so_oe_b = ~drive_q; // RL7

  // ---------------------------------------------------------------
  // Crossings into the core clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_rst_q <= 1'b1;
      cs_s1      <= 1'b1;
      cs_s2      <= 1'b1;
      cs_s3      <= 1'b1;
      arm_s1     <= 1'b0;
      arm_s2     <= 1'b0;
      fet_s1     <= 1'b0;
      fet_s2     <= 1'b0;
      fet_s3     <= 1'b0;
    end else begin
      link_rst_q <= 1'b0;
      cs_s1      <= cs_b;
      cs_s2      <= cs_s1;
      cs_s3      <= cs_s2;
      arm_s1     <= arm_tgl_q;
      arm_s2     <= arm_s1;
      fet_s1     <= fetch_tgl_q;
      fet_s2     <= fet_s1;
      fet_s3     <= fet_s2;
    end
  end

  assign cs_rise  = cs_s2 & ~cs_s3;
  assign arm_new  = arm_s2 ^ arm_seen_q;
  assign fet_edge = fet_s2 ^ fet_s3;
  assign ready    = (seq_q == sfce_pkg::SQ_IDLE);
  assign rdy      = ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_seen_q <= 1'b0;
    end else if (cs_rise) begin
      arm_seen_q <= arm_s2; // RL25
    end
  end

  // ---------------------------------------------------------------
  // Program and erase sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seq_q      <= sfce_pkg::SQ_IDLE;
      run_op_q   <= sfce_pkg::OP_PGM_ERS;
      run_bsel_q <= 1'b0;
      page_q     <= '0;
      byte_q     <= '0;
      tmr_q      <= '0;
    end else begin
      if (tmr_q != 32'h0) begin
        tmr_q <= tmr_q - 32'h1;
      end
      unique case (seq_q)
        sfce_pkg::SQ_IDLE: begin
          if (cs_rise && arm_new) begin // RL25
            seq_q      <= sfce_pkg::SQ_WALK;
            run_op_q   <= arm_op_q;
            run_bsel_q <= arm_bsel_q;
            byte_q     <= '0;
            page_q     <= arm_page_q;
            case (arm_op_q)
              sfce_pkg::OP_PGM_ERS: tmr_q <= EP_CYC; // RL18
              sfce_pkg::OP_PGM:     tmr_q <= P_CYC; // RL19
              sfce_pkg::OP_PG_ERS:  tmr_q <= PE_CYC; // RL21
              default: begin
                tmr_q  <= BE_CYC; // RL22
                page_q <= {arm_page_q[10:sfce_pkg::BLK_LSB], 3'h0};
              end
            endcase
          end
        end
        sfce_pkg::SQ_WALK: begin
          if (byte_q == sfce_pkg::PAGE_LAST) begin
            byte_q <= '0;
            if ((run_op_q == sfce_pkg::OP_BLK_ERS) && (page_q[2:0] != sfce_pkg::BLK_LAST)) begin
              page_q <= page_q + 11'h001; // RL22
            end else begin
              seq_q <= sfce_pkg::SQ_HOLD;
            end
          end else begin
            byte_q <= byte_q + 9'h001;
          end
        end
        sfce_pkg::SQ_HOLD: begin
          if (tmr_q == 32'h0) begin
            seq_q <= sfce_pkg::SQ_IDLE; // RL12
          end
        end
        default: seq_q <= sfce_pkg::SQ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Array port and page read fetch
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arr_req_q    <= '0;
      fetch_pend_q <= 1'b0;
      fetch_q      <= sfce_pkg::ERASED;
    end else begin
      arr_req_q.we <= (seq_q == sfce_pkg::SQ_WALK);
      if (seq_q == sfce_pkg::SQ_WALK) begin
        arr_req_q.page     <= page_q;
        arr_req_q.byte_idx <= byte_q;
        arr_req_q.and_mode <= (run_op_q == sfce_pkg::OP_PGM); // RL19
        arr_req_q.wdata    <= ((run_op_q == sfce_pkg::OP_PG_ERS) ||
                               (run_op_q == sfce_pkg::OP_BLK_ERS)) ?
                              sfce_pkg::ERASED : buf_mem_q[run_bsel_q][byte_q]; // RL18 RL21
      end else if (fet_edge) begin
        arr_req_q.page     <= hdr_q[sfce_pkg::PAGE_MSB:sfce_pkg::PAGE_LSB]; // RL2
        arr_req_q.byte_idx <= rd_ptr_q;
        arr_req_q.and_mode <= 1'b0;
      end
      fetch_pend_q <= fet_edge && (seq_q != sfce_pkg::SQ_WALK);
      if (fetch_pend_q) begin
        fetch_q <= arr_rdata; // RL5
      end
    end
  end

  assign arr_req = arr_req_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_take;
    cs_rise && arm_new && (seq_q == sfce_pkg::SQ_IDLE);
  endsequence

  chk_op_start: assert property (@(posedge clk) disable iff (!rst_b) // RL18
    s_take |=> (seq_q == sfce_pkg::SQ_WALK) ##1 arr_req_q.we)
    else $error("Armed command did not start walk");
  chk_busy_shown: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    s_take |=> !rdy [*8])
    else $error("Ready shown during operation");
  chk_partial_idle: assert property (@(posedge clk) disable iff (!rst_b) // RL25
    (cs_rise && !arm_new && (seq_q == sfce_pkg::SQ_IDLE)) |=> (seq_q == sfce_pkg::SQ_IDLE))
    else $error("Operation started without complete command");
  chk_erase_ones: assert property (@(posedge clk) disable iff (!rst_b) // RL21
    (arr_req_q.we && ((run_op_q == sfce_pkg::OP_PG_ERS) || (run_op_q == sfce_pkg::OP_BLK_ERS)))
    |-> (arr_req_q.wdata == sfce_pkg::ERASED))
    else $error("Erase wrote other than all ones");
  chk_pgm_and: assert property (@(posedge clk) disable iff (!rst_b) // RL19
    arr_req_q.we |-> (arr_req_q.and_mode == (run_op_q == sfce_pkg::OP_PGM)))
    else $error("Program mode does not match operation");
  chk_hiz_idle: assert property (@(posedge clk) disable iff (!rst_b) // RL7
    cs_s3 |-> so_oe_b)
    else $error("Output driven while deselected");
  chk_page_wrap: assert property (@(negedge sck) disable iff (cs_b) // RL4
    (in_rdata && (mode_q == sfce_pkg::M_PAGE_RD) && (obi_q == 3'h7) &&
     (rd_ptr_q == sfce_pkg::PAGE_LAST)) |=> (rd_ptr_q == 9'h000))
    else $error("Page read pointer did not wrap");
  chk_stat_repeat: assert property (@(negedge sck) disable iff (cs_b) // RL11
    (in_rdata && (mode_q == sfce_pkg::M_STAT) && (obi_q == 3'h7)) |=> (obi_q == 3'h0) && drive_q)
    else $error("Status byte did not repeat");
  chk_wr_wrap: assert property (@(posedge sck) disable iff (cs_b) // RL17
    (buf_we && (wptr_q == sfce_pkg::PAGE_LAST)) |=> (wptr_q == 9'h000))
    else $error("Buffer write pointer did not wrap");
  chk_read_no_wr: assert property (@(posedge sck) disable iff (cs_b) // RL5
    (mode_q == sfce_pkg::M_PAGE_RD) |-> !buf_we)
    else $error("Buffer written during page read");

endmodule

// ### tb/sfce_host.sv
/*
  Host model: serial master of the flash command engine, 80 ns bit time.
  Assumes so is taken just before each rising serial clock edge.
*/
`timescale 1ns/10ps
module sfce_host (
  output logic      sck,
  output logic      cs_b,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_b
);
  // ---------------------------------------------------------------
  // Frame control
  // ---------------------------------------------------------------
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end
  task automatic open_f();
    #13 cs_b = 1'b0;
    #40;
  endtask
  task automatic close_f();
    #40 cs_b = 1'b1;
    si = ~si;
    #200;
  endtask
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      si = b[i];
      #40 r[i] = so_oe_b ? ~so : so;
      sck = 1'b1;
      #40 sck = 1'b0;
    end
  endtask
endmodule

// ### tb/test_serial_flash_cmd_engine.sv
/*
  Testbench of the serial flash command engine with array and buffer models.
  Assumes the engine's ports as declared; time parameters shortened to 2 us.
*/
`timescale 1ns/10ps
module test_serial_flash_cmd_engine;
  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    sck, cs_b, si, so, so_oe_b, rdy;
  sfce_pkg::sfce_arr_req_t arr_req;
  logic [7:0]              mem [0:1048575];
  logic [7:0]              bufm [2][264];
  logic [7:0]              r;
  logic [31:0]             seed = 32'h8290022d;
  int                      n_mismatch = 0;
  int                      comparisons = 0;
  logic [7:0]              ops [7] = '{8'h81, 8'h88, 8'h50, 8'h86, 8'h83, 8'h50, 8'h89};
  int                      src [7] = '{2, 0, 2, 1, 0, 2, 1};
  logic [7:0]              rds [4] = '{8'h54, 8'hd4, 8'h56, 8'hd6};
  always #2.5 clk = ~clk;
  sfce_engine #(
    .ERASE_PROGRAM_TIME_MAX_US(2), .PROGRAM_TIME_MAX_US(2),
    .PAGE_ERASE_TIME_MAX_US(2), .BLOCK_ERASE_TIME_MAX_US(2), .DENSITY_CODE(4'h5)
  ) dut_u (
    .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so),
    .so_oe_b(so_oe_b), .rdy(rdy), .arr_req(arr_req), .arr_rdata(mem[{arr_req.page, arr_req.byte_idx}])
  );
  sfce_host host_u (.sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe_b(so_oe_b));
  // ---------------------------------------------------------------
  // Array model
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (arr_req.we) begin
      mem[{arr_req.page, arr_req.byte_idx}] <= arr_req.and_mode ?
        mem[{arr_req.page, arr_req.byte_idx}] & arr_req.wdata : arr_req.wdata;
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    host_u.open_f();
    host_u.xbyte(op, r);
    for (int i = 2; i >= 0; i--) host_u.xbyte(a[i*8+:8], r);
  endtask
  task automatic summarize();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_rdy();
    int k;
    for (k = 0; k < 5000 && rdy !== 1'b1; k++) @(posedge clk);
    if (k == 5000) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, rdy, 1'b1);
      summarize();
    end
  endtask
  task automatic poll_so();
    int k;
    host_u.open_f();
    host_u.xbyte(8'h57, r);
    #20;
    chk({7'h0, so}, 8'h00);
    for (k = 0; k < 5000 && so !== 1'b1; k++) @(posedge clk);
    #1;
    chk({7'h0, so}, 8'h01);
    if (k == 5000) summarize();
    host_u.close_f();
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 264; i++) mem[{11'd5, 9'(i)}] = 8'h00;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (10) @(posedge clk);
    foreach (rds[j]) begin
      hdr(j[0] ? 8'hd7 : 8'h57, 24'h0);
      chk(r & 8'hfc, 8'h94);
      for (int n = 0; n < 2; n++) begin
        host_u.xbyte(8'h00, r);
        chk(r & 8'hfc, 8'h94);
      end
      host_u.close_f();
      chk({7'h0, so_oe_b}, 8'h01);
    end
    $display("status read done");
    for (int b = 0; b < 2; b++) begin
      hdr(b ? 8'h87 : 8'h84, 24'd262);
      for (int i = 0; i < 4; i++) begin
        bufm[b][(262 + i) % 264] = rnd();
        host_u.xbyte(bufm[b][(262 + i) % 264], r);
      end
      host_u.close_f();
    end
    $display("buffer write done");
    foreach (ops[k]) begin
      hdr(ops[k], {4'h0, 11'd5, 9'd0});
      host_u.close_f();
      chk({7'h0, rdy}, 8'h00);
      poll_so();
      wait_rdy();
      hdr(k[0] ? 8'hd2 : 8'h52, {4'h0, 11'd5, 9'd262});
      for (int i = 0; i < 4; i++) host_u.xbyte(8'h00, r);
      for (int i = 0; i < 4; i++) begin
        host_u.xbyte(8'h00, r);
        chk(r, src[k] == 2 ? 8'hff : bufm[src[k]][(262 + i) % 264]);
      end
      host_u.close_f();
    end
    $display("program and erase done");
    foreach (rds[j]) begin
      hdr(rds[j], 24'd262);
      host_u.xbyte(8'h00, r);
      for (int i = 0; i < 4; i++) begin
        host_u.xbyte(8'h00, r);
        chk(r, bufm[j / 2][(262 + i) % 264]);
      end
      host_u.close_f();
    end
    $display("buffer read done");
    host_u.open_f();
    host_u.xbyte(8'h81, r);
    host_u.xbyte(8'h00, r);
    host_u.close_f();
    chk({7'h0, rdy}, 8'h01);
    $display("partial command done");
    summarize();
  end
endmodule
